// *** bst_consts.svh ***
`ifndef BST_CONSTS_SVH
`define BST_CONSTS_SVH

`define BST_IR_W        4
`define BST_DR_W        32
`define BST_PIN_N       8
`define BST_SYNC_W      11
`define BST_OP_EXTEST   4'h0
`define BST_OP_SAMPLE   4'h5
`define BST_OP_IDCODE   4'h6
`define BST_OP_USERSIG  4'h7
`define BST_OP_CFGLOAD  4'h8
`define BST_OP_BYPASS   4'hF
`define BST_IR_CAPTURE  4'h1

`endif

// *** bst_pkg.sv ***
package bst_pkg;

    typedef enum logic [3:0] {
        TLR, RTI, SEL_DR, CAP_DR, SHIFT_DR, EXIT1_DR, PAUSE_DR, EXIT2_DR,
        UPD_DR, SEL_IR, CAP_IR, SHIFT_IR, EXIT1_IR, PAUSE_IR, EXIT2_IR,
        UPD_IR
    } bst_state_type;

    typedef enum logic [2:0] {
        PATH_BSR, PATH_BYP, PATH_ID, PATH_USIG, PATH_CFG
    } bst_path_type;

endpackage : bst_pkg

// *** bst_sync.sv ***
`timescale 1ns/100ps

module bst_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rstn,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta_reg;

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    meta_reg[i] <= 1'b0;
                    q[i]        <= 1'b0;
                end else begin
                    meta_reg[i] <= d[i];
                    q[i]        <= meta_reg[i];
                end
            end
        end
    endgenerate

endmodule : bst_sync

// *** bst_tap.sv ***
`timescale 1ns/100ps
`include "bst_consts.svh"

module bst_tap #(
    // Arbitrary identification value
    parameter logic [31:0] ID_CODE = 32'h0000_1001
) (
    input  wire logic                   clk,
    input  wire logic                   rstn,
    input  wire logic                   tck,
    input  wire logic                   tms,
    input  wire logic                   tdi,
    output logic                        tdo,
    output logic                        tdo_oe,
    input  wire logic                   cfg_busy,
    input  wire logic [31:0]            user_sig,
    input  wire logic [`BST_PIN_N-1:0]  core_out,
    input  wire logic [`BST_PIN_N-1:0]  pin_in,
    output logic      [`BST_PIN_N-1:0]  pin_out,
    output logic                        cfg_bit,
    output logic                        cfg_bit_valid
);

    logic [`BST_SYNC_W-1:0] sync_q;
    logic                   tck_s;
    logic                   tms_s;
    logic                   tdi_s;
    logic [`BST_PIN_N-1:0]  pin_s;
    logic                   tck_rise;
    logic                   tck_fall;
    logic                   extest_act;
    bst_pkg::bst_path_type  path;

    bst_pkg::bst_state_type st_reg, st_next;
    logic                   tck_prev_reg, tck_prev_next;
    logic [`BST_IR_W-1:0]   ir_sh_reg, ir_sh_next;
    logic [`BST_IR_W-1:0]   ir_reg, ir_next;
    logic [`BST_DR_W-1:0]   dr_sh_reg, dr_sh_next;
    logic [`BST_PIN_N-1:0]  bsr_sh_reg, bsr_sh_next;
    logic [`BST_PIN_N-1:0]  bsr_upd_reg, bsr_upd_next;
    logic                   byp_reg, byp_next;
    logic                   tdo_next, tdo_oe_next;
    logic [`BST_PIN_N-1:0]  pin_out_next;
    logic                   cfg_bit_next, cfg_valid_next;

    bst_sync #(
        .W(`BST_SYNC_W)
    ) u_sync (
        .clk  (clk),
        .rstn (rstn),
        .d    ({pin_in, tdi, tms, tck}),
        .q    (sync_q)
    );

    assign tck_s    = sync_q[0];
    assign tms_s    = sync_q[1];
    assign tdi_s    = sync_q[2];
    assign pin_s    = sync_q[`BST_SYNC_W-1:3];
    assign tck_rise = tck_s & ~tck_prev_reg;
    assign tck_fall = ~tck_s & tck_prev_reg;

    function automatic bst_pkg::bst_path_type decode(
        input logic [`BST_IR_W-1:0] op,
        input logic                 busy
    );
        if ((op == `BST_OP_EXTEST || op == `BST_OP_SAMPLE) && busy)
            decode = bst_pkg::PATH_BYP;
        else if (op == `BST_OP_EXTEST || op == `BST_OP_SAMPLE)
            decode = bst_pkg::PATH_BSR;
        else if (op == `BST_OP_IDCODE)
            decode = bst_pkg::PATH_ID;
        else if (op == `BST_OP_USERSIG)
            decode = bst_pkg::PATH_USIG;
        else if (op == `BST_OP_CFGLOAD)
            decode = bst_pkg::PATH_CFG;
        else
            decode = bst_pkg::PATH_BYP;
    endfunction : decode

    function automatic bst_pkg::bst_state_type step(
        input bst_pkg::bst_state_type s,
        input logic                   m
    );
        case (s)
            bst_pkg::TLR:      step = m ? bst_pkg::TLR      : bst_pkg::RTI;
            bst_pkg::RTI:      step = m ? bst_pkg::SEL_DR   : bst_pkg::RTI;
            bst_pkg::SEL_DR:   step = m ? bst_pkg::SEL_IR   : bst_pkg::CAP_DR;
            bst_pkg::CAP_DR:   step = m ? bst_pkg::EXIT1_DR : bst_pkg::SHIFT_DR;
            bst_pkg::SHIFT_DR: step = m ? bst_pkg::EXIT1_DR : bst_pkg::SHIFT_DR;
            bst_pkg::EXIT1_DR: step = m ? bst_pkg::UPD_DR   : bst_pkg::PAUSE_DR;
            bst_pkg::PAUSE_DR: step = m ? bst_pkg::EXIT2_DR : bst_pkg::PAUSE_DR;
            bst_pkg::EXIT2_DR: step = m ? bst_pkg::UPD_DR   : bst_pkg::SHIFT_DR;
            bst_pkg::UPD_DR:   step = m ? bst_pkg::SEL_DR   : bst_pkg::RTI;
            bst_pkg::SEL_IR:   step = m ? bst_pkg::TLR      : bst_pkg::CAP_IR;
            bst_pkg::CAP_IR:   step = m ? bst_pkg::EXIT1_IR : bst_pkg::SHIFT_IR;
            bst_pkg::SHIFT_IR: step = m ? bst_pkg::EXIT1_IR : bst_pkg::SHIFT_IR;
            bst_pkg::EXIT1_IR: step = m ? bst_pkg::UPD_IR   : bst_pkg::PAUSE_IR;
            bst_pkg::PAUSE_IR: step = m ? bst_pkg::EXIT2_IR : bst_pkg::PAUSE_IR;
            bst_pkg::EXIT2_IR: step = m ? bst_pkg::UPD_IR   : bst_pkg::SHIFT_IR;
            default:           step = m ? bst_pkg::SEL_DR   : bst_pkg::RTI;
        endcase
    endfunction : step

    assign path       = decode(ir_reg, cfg_busy);
    assign extest_act = (ir_reg == `BST_OP_EXTEST) && !cfg_busy;

    always_comb begin
        tck_prev_next  = tck_s;
        st_next        = st_reg;
        ir_sh_next     = ir_sh_reg;
        ir_next        = ir_reg;
        dr_sh_next     = dr_sh_reg;
        bsr_sh_next    = bsr_sh_reg;
        bsr_upd_next   = bsr_upd_reg;
        byp_next       = byp_reg;
        tdo_next       = tdo;
        tdo_oe_next    = tdo_oe;
        cfg_bit_next   = cfg_bit;
        cfg_valid_next = 1'b0;
        // Core keeps the pins unless external test owns them
        pin_out_next   = extest_act ? bsr_upd_reg : core_out;
        if (tck_rise) begin
            st_next = step(st_reg, tms_s);
            case (st_reg)
                bst_pkg::TLR: begin
                    ir_next = `BST_OP_IDCODE;
                end
                bst_pkg::CAP_IR: begin
                    ir_sh_next = `BST_IR_CAPTURE;
                end
                bst_pkg::SHIFT_IR: begin
                    ir_sh_next = {tdi_s, ir_sh_reg[`BST_IR_W-1:1]};
                end
                bst_pkg::UPD_IR: begin
                    ir_next = ir_sh_reg;
                end
                bst_pkg::CAP_DR: begin
                    if (path == bst_pkg::PATH_BSR)
                        bsr_sh_next = pin_s;
                    else if (path == bst_pkg::PATH_ID)
                        dr_sh_next = {ID_CODE[31:1], 1'b1};
                    else if (path == bst_pkg::PATH_USIG)
                        dr_sh_next = user_sig;
                    else
                        byp_next = 1'b0;
                end
                bst_pkg::SHIFT_DR: begin
                    if (path == bst_pkg::PATH_BSR) begin
                        bsr_sh_next = {tdi_s, bsr_sh_reg[`BST_PIN_N-1:1]};
                    end else if (path == bst_pkg::PATH_ID ||
                                 path == bst_pkg::PATH_USIG) begin
                        dr_sh_next = {tdi_s, dr_sh_reg[`BST_DR_W-1:1]};
                    end else begin
                        byp_next = tdi_s;
                    end
                    if (path == bst_pkg::PATH_CFG) begin
                        cfg_bit_next   = tdi_s;
                        cfg_valid_next = 1'b1;
                    end
                end
                bst_pkg::UPD_DR: begin
                    if (path == bst_pkg::PATH_BSR)
                        bsr_upd_next = bsr_sh_reg;
                end
                default: begin
                end
            endcase
        end
        if (tck_fall) begin
            tdo_oe_next = (st_reg == bst_pkg::SHIFT_DR) ||
                          (st_reg == bst_pkg::SHIFT_IR);
            if (st_reg == bst_pkg::SHIFT_IR)
                tdo_next = ir_sh_reg[0];
            else if (path == bst_pkg::PATH_BSR)
                tdo_next = bsr_sh_reg[0];
            else if (path == bst_pkg::PATH_ID || path == bst_pkg::PATH_USIG)
                tdo_next = dr_sh_reg[0];
            else
                tdo_next = byp_reg;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_reg        <= bst_pkg::TLR;
            tck_prev_reg  <= 1'b0;
            ir_sh_reg     <= '0;
            ir_reg        <= `BST_OP_IDCODE;
            dr_sh_reg     <= '0;
            bsr_sh_reg    <= '0;
            bsr_upd_reg   <= '0;
            byp_reg       <= 1'b0;
            tdo           <= 1'b0;
            tdo_oe        <= 1'b0;
            pin_out       <= '0;
            cfg_bit       <= 1'b0;
            cfg_bit_valid <= 1'b0;
        end else begin
            st_reg        <= st_next;
            tck_prev_reg  <= tck_prev_next;
            ir_sh_reg     <= ir_sh_next;
            ir_reg        <= ir_next;
            dr_sh_reg     <= dr_sh_next;
            bsr_sh_reg    <= bsr_sh_next;
            bsr_upd_reg   <= bsr_upd_next;
            byp_reg       <= byp_next;
            tdo           <= tdo_next;
            tdo_oe        <= tdo_oe_next;
            pin_out       <= pin_out_next;
            cfg_bit       <= cfg_bit_next;
            cfg_bit_valid <= cfg_valid_next;
        end
    end

    sequence s_cap_dr;
        tck_rise && st_reg == bst_pkg::CAP_DR;
    endsequence

    sequence s_shift_dr;
        tck_rise && st_reg == bst_pkg::SHIFT_DR;
    endsequence

    property p_tlr_id;
        @(posedge clk) disable iff (!rstn)
        tck_rise && st_reg == bst_pkg::TLR |=> ir_reg == `BST_OP_IDCODE;
    endproperty
    a_tlr_id: assert property (p_tlr_id) else $error("reset state lost id");

    property p_busy_block;
        @(posedge clk) disable iff (!rstn)
        cfg_busy |-> path != bst_pkg::PATH_BSR && !extest_act
                     ##1 pin_out == $past(core_out);
    endproperty
    a_busy_block: assert property (p_busy_block) else $error("scan in config");

    property p_sample;
        @(posedge clk) disable iff (!rstn)
        s_cap_dr ##0 path == bst_pkg::PATH_BSR |=> bsr_sh_reg == $past(pin_s);
    endproperty
    a_sample: assert property (p_sample) else $error("pin capture wrong");

    property p_preload;
        @(posedge clk) disable iff (!rstn)
        tck_rise && st_reg == bst_pkg::UPD_DR && path == bst_pkg::PATH_BSR
        |=> bsr_upd_reg == $past(bsr_sh_reg);
    endproperty
    a_preload: assert property (p_preload) else $error("update stage wrong");

    property p_pins;
        @(posedge clk) disable iff (!rstn)
        1'b1 |=> pin_out == ($past(extest_act) ? $past(bsr_upd_reg)
                                               : $past(core_out));
    endproperty
    a_pins: assert property (p_pins) else $error("pin drive wrong");

    property p_bypass;
        @(posedge clk) disable iff (!rstn)
        s_shift_dr ##0 path == bst_pkg::PATH_BYP |=> byp_reg == $past(tdi_s);
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass shift wrong");

    property p_usig;
        @(posedge clk) disable iff (!rstn)
        s_cap_dr ##0 path == bst_pkg::PATH_USIG |=> dr_sh_reg == $past(user_sig);
    endproperty
    a_usig: assert property (p_usig) else $error("signature capture wrong");

    property p_id;
        @(posedge clk) disable iff (!rstn)
        s_cap_dr ##0 path == bst_pkg::PATH_ID
        |=> dr_sh_reg[0] && dr_sh_reg == {ID_CODE[31:1], 1'b1};
    endproperty
    a_id: assert property (p_id) else $error("id capture wrong");

    property p_cfg;
        @(posedge clk) disable iff (!rstn)
        s_shift_dr ##0 path == bst_pkg::PATH_CFG
        |=> cfg_bit_valid && cfg_bit == $past(tdi_s) ##1 !cfg_bit_valid;
    endproperty
    a_cfg: assert property (p_cfg) else $error("config bit wrong");

    property p_byp_zero;
        @(posedge clk) disable iff (!rstn)
        s_cap_dr ##0 path == bst_pkg::PATH_BYP |=> !byp_reg;
    endproperty
    a_byp_zero: assert property (p_byp_zero) else $error("bypass not zero");

endmodule : bst_tap

// *** bst_host.sv ***
`timescale 1ns/100ps

module bst_host (
    input  wire logic clk,
    input  wire logic tdo,
    output logic      tck,
    output logic      tms,
    output logic      tdi
);
    logic tdo_s;

    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end

    // One test clock period; clock idles low between frames
    task automatic step(input logic m, input logic d);
        tms = m;
        tdi = d;
        repeat (6) @(posedge clk);
        #1;
        tdo_s = tdo;
        tck = 1'b1;
        repeat (6) @(posedge clk);
        #1;
        tck = 1'b0;
    endtask : step

    task automatic reset_tap();
        repeat (5) step(1'b1, ~tdi);
        step(1'b0, ~tdi);
    endtask : reset_tap

    // From idle through capture, shift LSB first, update, back to idle
    task automatic shift(input logic ir, input int n,
                         input logic [31:0] din, output logic [31:0] dout);
        int i;
        dout = '0;
        step(1'b1, ~tdi);
        if (ir) step(1'b1, ~tdi);
        step(1'b0, ~tdi);
        step(1'b0, ~tdi);
        for (i = 0; i < n; i++) begin
            step(i == n - 1, din[i]);
            dout[i] = tdo_s;
        end
        step(1'b1, ~tdi);
        step(1'b0, ~tdi);
    endtask : shift
endmodule : bst_host

// *** bst_tap_tb.sv ***
`timescale 1ns/100ps
`include "bst_consts.svh"

module bst_tap_tb;
    // Arbitrary identification value, even so the forced bit0 shows
    localparam logic [31:0] ID_VAL = 32'h1234_5678;
    logic                  clk, rstn, tck, tms, tdi, tdo, tdo_oe;
    logic                  cfg_busy, cfg_bit, cfg_bit_valid;
    logic [31:0]           user_sig, res, cfg_seen;
    logic [`BST_PIN_N-1:0] core_out, pin_in, pin_out;
    int                    cfg_cnt, oe_cnt, miscompares, cmp_count;

    bst_tap #(.ID_CODE(ID_VAL)) bst_tap_inst (
        .clk(clk), .rstn(rstn), .tck(tck), .tms(tms), .tdi(tdi),
        .tdo(tdo), .tdo_oe(tdo_oe), .cfg_busy(cfg_busy),
        .user_sig(user_sig), .core_out(core_out), .pin_in(pin_in),
        .pin_out(pin_out), .cfg_bit(cfg_bit),
        .cfg_bit_valid(cfg_bit_valid));

    bst_host bst_host_inst (
        .clk(clk), .tdo(tdo), .tck(tck), .tms(tms), .tdi(tdi));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    always @(negedge clk) begin
        if (cfg_bit_valid === 1'b1) begin
            cfg_seen = {cfg_bit, cfg_seen[31:1]};
            cfg_cnt++;
        end
    end

    // Count test clock rises that find the output enabled
    always @(posedge tck) begin
        if (tdo_oe === 1'b1)
            oe_cnt++;
    end

    task automatic chk(input string name, input logic [31:0] exp,
                       input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : conclude

    task automatic load_ir(input logic [3:0] op);
        bst_host_inst.shift(1'b1, 4, {28'h0, op}, res);
        chk("ir_capture", {28'h0, `BST_IR_CAPTURE}, res);
    endtask : load_ir

    task automatic t_id();
        bst_host_inst.shift(1'b0, 32, 32'h0, res);
        chk("id_after_reset", {ID_VAL[31:1], 1'b1}, res);
        load_ir(`BST_OP_IDCODE);
        oe_cnt = 0;
        bst_host_inst.shift(1'b0, 32, 32'hFFFF_FFFF, res);
        chk("idcode", {ID_VAL[31:1], 1'b1}, res);
        chk("tdo_oe_shift", 32'h20, oe_cnt);
        chk("tdo_oe_idle", 32'h0, {31'h0, tdo_oe});
    endtask : t_id

    task automatic t_usig();
        user_sig = 32'hC3A5_0F96;
        load_ir(`BST_OP_USERSIG);
        bst_host_inst.shift(1'b0, 32, 32'hFFFF_FFFF, res);
        chk("user_sig", 32'hC3A5_0F96, res);
    endtask : t_usig

    task automatic t_byp();
        core_out = 8'h96;
        load_ir(`BST_OP_BYPASS);
        bst_host_inst.shift(1'b0, 8, 32'hB4, res);
        chk("bypass_out", 32'h68, res);
        chk("bypass_pins", 32'h96, {24'h0, pin_out});
    endtask : t_byp

    task automatic t_bsr();
        pin_in = 8'h5A;
        core_out = 8'h3C;
        load_ir(`BST_OP_SAMPLE);
        bst_host_inst.shift(1'b0, 8, 32'hC6, res);
        chk("sample_cap", 32'h5A, res);
        chk("sample_pins", 32'h3C, {24'h0, pin_out});
        load_ir(`BST_OP_EXTEST);
        chk("preload_pins", 32'hC6, {24'h0, pin_out});
        pin_in = 8'h81;
        bst_host_inst.shift(1'b0, 8, 32'h29, res);
        chk("extest_cap", 32'h81, res);
        chk("extest_pins", 32'h29, {24'h0, pin_out});
    endtask : t_bsr

    task automatic t_busy();
        cfg_busy = 1'b1;
        core_out = 8'hE7;
        load_ir(`BST_OP_EXTEST);
        bst_host_inst.shift(1'b0, 8, 32'hB4, res);
        chk("busy_out", 32'h68, res);
        chk("busy_pins", 32'hE7, {24'h0, pin_out});
        cfg_busy = 1'b0;
        load_ir(`BST_OP_BYPASS);
    endtask : t_busy

    task automatic t_cfg();
        load_ir(`BST_OP_CFGLOAD);
        cfg_cnt = 0;
        bst_host_inst.shift(1'b0, 8, 32'hD2, res);
        chk("cfg_count", 32'h8, cfg_cnt);
        chk("cfg_bits", 32'hD2, {24'h0, cfg_seen[31:24]});
        chk("cfg_tdo", 32'hA4, res);
    endtask : t_cfg

    initial begin
        rstn = 1'b0;
        cfg_busy = 1'b0;
        user_sig = 32'h0;
        core_out = 8'h00;
        pin_in = 8'h00;
        cfg_seen = 32'h0;
        cfg_cnt = 0;
        miscompares = 0;
        cmp_count = 0;
        repeat (12) @(posedge clk);
        #1;
        rstn = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        bst_host_inst.reset_tap();
        t_id();
        t_usig();
        t_byp();
        t_bsr();
        t_busy();
        t_cfg();
        conclude();
    end

    initial begin
        #200000;
        miscompares++;
        $display("BAD watchdog expected done seen hang");
        conclude();
    end
endmodule : bst_tap_tb
